// ---- verilog/bcw_top.sv ----
// Bus cycle controller with wait state generation and bus release.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
// Summary of operation
// - Reset pin low six or more clocks restarts execution at address 00000H.
// - Bus hold request low asks for the bus; grant driven low after release.
// - Release only at cycle boundary; bus cycles T1 T2 T3 plus waits.
// - While released, address, data and request strobes float.
// - No refresh while released; the other master refreshes memory itself.
// - Hold request sampled before T3, T1 and each release state.
// - Waits come from external wait OR internal generator, CPU and DMA alike.
// - External wait sampled in T2 and each wait state; low adds a wait.
// - No refresh during wait states.
// - Memory wait field bits 7:6 add 0 to 3 waits.
// - I/O wait field bits 5:4 give 1 to 4 waits.
// - Zeroth interrupt acknowledge with fetch strobe low gets 2,4,5,6 waits.
// - Other interrupt acknowledges get 2 waits; nonmaskable gets 0.
// - Wait count is the larger of external and internal requests.
// - On-chip I/O range 0000H-003FH ignores the I/O wait field.
// - On-chip data registers get 4 waits; others none, three clocks.
// - Acknowledge cycles with fetch strobe high use memory timing and waits.
// - Reset sets all four wait field bits to one.
// - Wait ignored in reset; reset aborts a waited cycle.
// - Indexed store runs two fetches, displacement read, idle, then write.
// - Bus cycles are T1, T2, waits, T3; internal operation is T1 only.
module bcw_top (
	// System
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Device pins
	input  wire logic        reset_pin_n,
	input  wire logic        wait_n,
	input  wire logic        bus_hold_request_n,
	output logic             bus_hold_grant_n,
	output logic             restart_q,
	output logic             refresh_allow,
	output logic [19:0]      addr_out,
	output logic             addr_oe_n,
	output logic             memory_request_strobe_n,
	output logic             io_request_strobe_n,
	output logic             opcode_fetch_strobe_n,
	output logic             strobe_oe_n,
	output logic             data_oe_n
);

	// ==========================================================
	// Registers
	logic [7:0]          dwc_q;
	logic                go_q;
	bcw_pkg::bcw_kind_t  kind_q;
	logic                fetch_q;
	logic [19:0]         cyc_addr_q;
	bcw_pkg::bcw_state_t st_q;
	logic [2:0]          wcnt_q;
	logic [2:0]          rst_cnt_q;
	logic                in_reset;
	logic [2:0]          int_waits;
	logic                is_bus_cycle;

	// Internal wait count for the cycle kind held in the control register.
	function automatic logic [2:0] gen_waits(input bcw_pkg::bcw_kind_t k, input logic f,
		input logic [1:0] mw, input logic [1:0] iw, input logic [19:0] a);
		logic [2:0] r;
		r = 3'h0;
		case (k)
			bcw_pkg::MC_MEM: r = {1'b0, mw};
			bcw_pkg::MC_IO: begin
				if (a <= bcw_pkg::ONCHIP_IO_TOP)
					r = 3'h0;
				else
					r = {1'b0, iw} + 3'h1;
			end
			bcw_pkg::MC_DATA_REG: r = bcw_pkg::DATA_REG_W;
			bcw_pkg::MC_EXT_IRQ_ZERO_ACK: begin
				if (!f)
					r = {1'b0, mw};
				else begin
					case (iw)
						2'b00:   r = bcw_pkg::EXT_IRQ_ZERO_W00;
						2'b01:   r = bcw_pkg::EXT_IRQ_ZERO_W01;
						2'b10:   r = bcw_pkg::EXT_IRQ_ZERO_W10;
						default: r = bcw_pkg::EXT_IRQ_ZERO_W11;
					endcase
				end
			end
			// The fetch bit set means the fetch strobe is driven low in this cycle.
			bcw_pkg::MC_INTX_ACK: r = f ? bcw_pkg::INTX_W : {1'b0, mw};
			bcw_pkg::MC_NMI_ACK: r = f ? bcw_pkg::NMI_W : {1'b0, mw};
			default: r = 3'h0;
		endcase
		return r;
	endfunction : gen_waits

	assign in_reset = (rst_cnt_q == 3'(bcw_pkg::RESET_HOLD_CYCLES));
	assign int_waits = gen_waits(kind_q, fetch_q, dwc_q[bcw_pkg::MWS_HI:bcw_pkg::MWS_LO],
		dwc_q[bcw_pkg::IWS_HI:bcw_pkg::IWS_LO], cyc_addr_q);
	assign is_bus_cycle = (kind_q != bcw_pkg::MC_INTERNAL);

	// ==========================================================
	// Reset pin qualification: counts held-low clocks.
	always_ff @(posedge clk_sys) begin
		if (rst)
			rst_cnt_q <= 3'h0;
		else if (reset_pin_n)
			rst_cnt_q <= 3'h0;
		else if (!in_reset)
			rst_cnt_q <= rst_cnt_q + 3'h1;
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			restart_q <= 1'b0;
		else
			restart_q <= in_reset;
	end

	// ==========================================================
	// APB slave: zero-wait, answers in the access phase.
	always_ff @(posedge clk_sys) begin
		if (rst || in_reset) begin
			dwc_q <= bcw_pkg::DWC_RESET;
		end else if (psel && penable && pwrite && paddr == bcw_pkg::ADDR_DWC) begin
			dwc_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || in_reset) begin
			go_q       <= 1'b0;
			kind_q     <= bcw_pkg::MC_INTERNAL;
			fetch_q    <= 1'b0;
			cyc_addr_q <= bcw_pkg::RESTART_ADDR;
		end else if (psel && penable && pwrite && paddr == bcw_pkg::ADDR_CTRL) begin
			go_q       <= pwdata[bcw_pkg::CTRL_GO];
			kind_q     <= bcw_pkg::bcw_kind_t'(pwdata[bcw_pkg::CTRL_KIND_HI:bcw_pkg::CTRL_KIND_LO]);
			fetch_q    <= pwdata[bcw_pkg::CTRL_FETCH];
			cyc_addr_q <= pwdata[bcw_pkg::CTRL_ADDR_HI:bcw_pkg::CTRL_ADDR_LO];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (psel && !penable) begin
				case (paddr)
					bcw_pkg::ADDR_DWC:    prdata <= {24'h0, dwc_q};
					bcw_pkg::ADDR_CTRL:   prdata <= {4'h0, cyc_addr_q, 3'h0, fetch_q, kind_q, go_q};
					bcw_pkg::ADDR_STATUS: prdata <= {24'h0, wcnt_q, ~bus_hold_grant_n, 1'b0, st_q};
					default:              pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// Machine cycle sequencer. Pins are synchronous, so the falling-edge
	// samples are taken at the rising edge that ends the state before.
	always_ff @(posedge clk_sys) begin
		if (rst || in_reset) begin
			st_q   <= bcw_pkg::ST_IDLE;
			wcnt_q <= 3'h0;
		end else begin
			case (st_q)
				bcw_pkg::ST_IDLE: begin
					if (!bus_hold_request_n)
						st_q <= bcw_pkg::ST_TX;
					else if (go_q)
						st_q <= bcw_pkg::ST_T1;
				end
				bcw_pkg::ST_T1: begin
					wcnt_q <= 3'h0;
					if (is_bus_cycle)
						st_q <= bcw_pkg::ST_T2;
					else if (!bus_hold_request_n)
						st_q <= bcw_pkg::ST_TX;
					else
						st_q <= go_q ? bcw_pkg::ST_T1 : bcw_pkg::ST_IDLE;
				end
				bcw_pkg::ST_T2, bcw_pkg::ST_TW: begin
					// Larger of the two counts equals the OR of the two requests.
					if (!wait_n || wcnt_q < int_waits) begin
						st_q   <= bcw_pkg::ST_TW;
						wcnt_q <= wcnt_q + 3'h1;
					end else
						st_q <= bcw_pkg::ST_T3;
				end
				bcw_pkg::ST_T3: begin
					if (!bus_hold_request_n)
						st_q <= bcw_pkg::ST_TX;
					else
						st_q <= go_q ? bcw_pkg::ST_T1 : bcw_pkg::ST_IDLE;
				end
				bcw_pkg::ST_TX: begin
					if (bus_hold_request_n)
						st_q <= go_q ? bcw_pkg::ST_T1 : bcw_pkg::ST_IDLE;
				end
				default: st_q <= bcw_pkg::ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pin drivers, all registered; strobes, grant and enables from the current st_q, one clock behind the state.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_hold_grant_n        <= 1'b1;
			refresh_allow           <= 1'b0;
			addr_out                <= bcw_pkg::RESTART_ADDR;
			addr_oe_n               <= 1'b0;
			strobe_oe_n             <= 1'b0;
			data_oe_n               <= 1'b1;
			memory_request_strobe_n <= 1'b1;
			io_request_strobe_n     <= 1'b1;
			opcode_fetch_strobe_n   <= 1'b1;
		end else begin
			bus_hold_grant_n <= (st_q != bcw_pkg::ST_TX);
			// Refresh never runs in waits or while the bus is away.
			refresh_allow <= (st_q != bcw_pkg::ST_TX) && (st_q != bcw_pkg::ST_TW);
			addr_oe_n     <= (st_q == bcw_pkg::ST_TX);
			strobe_oe_n   <= (st_q == bcw_pkg::ST_TX);
			data_oe_n     <= 1'b1;
			addr_out      <= in_reset ? bcw_pkg::RESTART_ADDR : cyc_addr_q;
			memory_request_strobe_n <= !(is_bus_cycle && kind_q != bcw_pkg::MC_IO &&
				kind_q != bcw_pkg::MC_DATA_REG && (st_q == bcw_pkg::ST_T2 || st_q == bcw_pkg::ST_TW));
			io_request_strobe_n <= !((kind_q == bcw_pkg::MC_IO || kind_q == bcw_pkg::MC_DATA_REG) &&
				(st_q == bcw_pkg::ST_T2 || st_q == bcw_pkg::ST_TW));
			// Two fetch cycles of an indexed store are issued by software with the fetch bit set.
			opcode_fetch_strobe_n <= !(fetch_q && (st_q == bcw_pkg::ST_T2 || st_q == bcw_pkg::ST_TW));
		end
	end

endmodule : bcw_top

// ---- verilog/bcw_pkg.sv ----
// Package of constants for the bus cycle wait and release controller.
package bcw_pkg;

	// ==========================================================
	// APB register map
	localparam logic [7:0] ADDR_DWC    = 8'h00;
	localparam logic [7:0] ADDR_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// ==========================================================
	// Wait control register fields
	localparam int MWS_HI = 7;
	localparam int MWS_LO = 6;
	localparam int IWS_HI = 5;
	localparam int IWS_LO = 4;
	localparam logic [7:0] DWC_RESET = 8'hF0;

	// ==========================================================
	// Control register fields
	localparam int CTRL_GO     = 0;
	localparam int CTRL_KIND_LO = 1;
	localparam int CTRL_KIND_HI = 3;
	localparam int CTRL_FETCH  = 4;
	localparam int CTRL_ADDR_LO = 8;
	localparam int CTRL_ADDR_HI = 27;

	// ==========================================================
	// Reset timing and addresses
	localparam int RESET_HOLD_CYCLES = 6;
	localparam logic [19:0] RESTART_ADDR = 20'h00000;
	localparam logic [19:0] ONCHIP_IO_TOP = 20'h0003F;

	// ==========================================================
	// Wait counts for interrupt acknowledge and on-chip data registers
	localparam logic [2:0] EXT_IRQ_ZERO_W00 = 3'h2;
	localparam logic [2:0] EXT_IRQ_ZERO_W01 = 3'h4;
	localparam logic [2:0] EXT_IRQ_ZERO_W10 = 3'h5;
	localparam logic [2:0] EXT_IRQ_ZERO_W11 = 3'h6;
	localparam logic [2:0] INTX_W   = 3'h2;
	localparam logic [2:0] NMI_W    = 3'h0;
	localparam logic [2:0] DATA_REG_W = 3'h4;

	// ==========================================================
	// Machine cycle kinds
	typedef enum logic [2:0] {
		MC_INTERNAL = 3'b000,
		MC_MEM      = 3'b001,
		MC_IO       = 3'b010,
		MC_EXT_IRQ_ZERO_ACK = 3'b011,
		MC_INTX_ACK = 3'b100,
		MC_NMI_ACK  = 3'b101,
		MC_DATA_REG = 3'b110
	} bcw_kind_t;

	// Clock states of a machine cycle.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_T1   = 3'b001,
		ST_T2   = 3'b010,
		ST_TW   = 3'b011,
		ST_T3   = 3'b100,
		ST_TX   = 3'b101
	} bcw_state_t;

endpackage : bcw_pkg

// ---- tb/bcw_far_model.sv ----
// Alternate bus master and slow peripheral facing the controller.
`timescale 1ns/1ns
module bcw_far_model (
	// Bench commands
	input  wire logic clk_sys,
	input  wire logic want,
	input  wire logic stall,
	// Device pins
	output logic      bus_hold_request_n = 1'b1,
	output logic      wait_n = 1'b1
);
	// Both lines move just after the edge, as a synchronised master would.
	always @(posedge clk_sys) begin
		bus_hold_request_n <= !want;
		wait_n <= !stall;
	end
	// No memory is modelled, so long holds need no refresh here.
endmodule : bcw_far_model

// ---- tb/bcw_top_properties.sv ----
// Pin-level checks of the bus cycle controller.
`timescale 1ns/1ns
module bcw_properties (
	// Pins watched
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        reset_pin_n,
	input wire logic        wait_n,
	input wire logic        bus_hold_request_n,
	input wire logic        bus_hold_grant_n,
	input wire logic        restart_q,
	input wire logic        refresh_allow,
	input wire logic [19:0] addr_out,
	input wire logic        addr_oe_n,
	input wire logic        strobe_oe_n,
	input wire logic        memory_request_strobe_n,
	input wire logic        io_request_strobe_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================================
	// Sequences
	sequence pin_low;
		!reset_pin_n [*6];
	endsequence
	sequence waited;
		(!wait_n && !memory_request_strobe_n) [*3];
	endsequence
	// The first cycle of a release may still carry the previous drive.
	sequence released;
		!bus_hold_grant_n && $past(!bus_hold_grant_n) && $past(!bus_hold_request_n);
	endsequence
	// ==========================================================
	// Properties
	a_restart_qual: assert property (pin_low |-> ##[0:2] restart_q)
		else $error("no restart after long reset");
	a_restart_addr: assert property (restart_q && $past(restart_q) |-> addr_out == 20'h00000)
		else $error("restart address wrong");
	a_release_float: assert property (released |-> addr_oe_n && strobe_oe_n)
		else $error("bus driven while released");
	a_release_quiet: assert property (released |-> memory_request_strobe_n && io_request_strobe_n)
		else $error("strobe active while released");
	a_release_norefresh: assert property (released |-> !refresh_allow)
		else $error("refresh while released");
	a_grant_cause: assert property ($fell(bus_hold_grant_n) |-> $past(!bus_hold_request_n, 2))
		else $error("grant without request");
	a_grant_timely: assert property ($fell(bus_hold_request_n) && wait_n |-> ##[1:20] !bus_hold_grant_n)
		else $error("grant late");
	a_wait_norefresh: assert property (waited |-> !refresh_allow)
		else $error("refresh in wait state");
	a_wait_extends: assert property (waited ##0 reset_pin_n |=> !memory_request_strobe_n)
		else $error("wait not extended");
	a_reset_abort: assert property (pin_low |-> ##3 (memory_request_strobe_n && io_request_strobe_n))
		else $error("cycle not aborted by reset");
endmodule : bcw_properties
bind bcw_top bcw_properties u_bcw_properties (.clk_sys, .rst, .reset_pin_n, .wait_n, .bus_hold_request_n,
	.bus_hold_grant_n, .restart_q, .refresh_allow, .addr_out, .addr_oe_n, .strobe_oe_n,
	.memory_request_strobe_n, .io_request_strobe_n);

// ---- tb/bcw_top_test.sv ----
// Self-checking bench for the bus cycle controller.
`timescale 1ns/1ns
module bcw_top_test;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        reset_pin_n = 1'b1;
	logic        want = 1'b0;
	logic        stall = 1'b0;
	logic [31:0] prdata;
	logic [19:0] addr_out;
	logic        pready, pslverr, wait_n, bus_hold_request_n, bus_hold_grant_n, restart_q, refresh_allow;
	logic        addr_oe_n, memory_request_strobe_n, io_request_strobe_n, opcode_fetch_strobe_n, strobe_oe_n;
	logic        data_oe_n;
	logic [31:0] seed = 32'hF;
	logic [31:0] r;
	logic [64:0] ew;
	logic [64:0] exp_rd[$];
	int          exp_run[$];
	int          run = 0;
	int          n_errors = 0;
	int          n_compared = 0;
	// Fields: on-chip, kind, fetch, wait code, strobe length.
	localparam logic [19:0] TBL [17] = '{20'h01031, 20'h01072, 20'h010B3, 20'h010F4, 20'h02002, 20'h02013,
		20'h02024, 20'h02035, 20'h12031, 20'h16005, 20'h03103, 20'h03115, 20'h03126, 20'h03137, 20'h04103,
		20'h05101, 20'h03083};
	always #25 clk_sys = ~clk_sys;
	bcw_top u_bcw_top (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.reset_pin_n, .wait_n, .bus_hold_request_n, .bus_hold_grant_n, .restart_q, .refresh_allow, .addr_out,
		.addr_oe_n, .memory_request_strobe_n, .io_request_strobe_n, .opcode_fetch_strobe_n, .strobe_oe_n,
		.data_oe_n);
	bcw_far_model u_bcw_far_model (.clk_sys, .want, .stall, .bus_hold_request_n, .wait_n);
	// ==========================================================
	// Helpers
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic err);
		exp_rd.push_back({err, m, e});
		apb(1'b0, a, 32'h0);
	endtask : rd
	// ==========================================================
	// Watcher: read data and strobe lengths against the oldest note.
	always @(posedge clk_sys) begin
		if (psel && penable && pready && !pwrite && exp_rd.size() > 0) begin
			ew = exp_rd.pop_front();
			chk("pslverr", {31'h0, ew[64]}, {31'h0, pslverr});
			if (!ew[64]) chk("prdata", ew[31:0], prdata & ew[63:32]);
		end
		if (memory_request_strobe_n === 1'b0 || io_request_strobe_n === 1'b0) run++;
		else if (run > 0) begin
			if (exp_run.size() > 0) chk("strobe length", exp_run.pop_front(), run);
			run = 0;
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd(bcw_pkg::ADDR_DWC, 32'hF0, {24'h0, bcw_pkg::DWC_RESET}, 1'b0);
		rd(8'h0C, 32'h0, 32'h0, 1'b1);
		r = xs();
		apb(1'b1, bcw_pkg::ADDR_DWC, {24'h0, r[7:4], 4'h0});
		rd(bcw_pkg::ADDR_DWC, 32'hF0, {24'h0, r[7:4], 4'h0}, 1'b0);
		$display("registers done");
		foreach (TBL[i]) begin
			apb(1'b1, bcw_pkg::ADDR_CTRL, 32'h0);
			repeat (12) @(posedge clk_sys);
			r = xs();
			r[19:0] = TBL[i][16] ? 20'h00010 : {4'h0, r[15:8], 8'h40};
			apb(1'b1, bcw_pkg::ADDR_DWC, {24'h0, TBL[i][7:4], 4'h0});
			exp_run.push_back(TBL[i][3:0]);
			apb(1'b1, bcw_pkg::ADDR_CTRL, {4'h0, r[19:0], 3'h0, TBL[i][8], TBL[i][14:12], 1'b1});
			for (int n = 0; n < 60 && exp_run.size() > 0; n++) @(posedge clk_sys);
			if (exp_run.size() > 0) begin
				n_errors++;
				conclude();
			end
		end
		$display("wait table done");
		apb(1'b1, bcw_pkg::ADDR_DWC, 32'h0);
		stall <= 1'b1;
		apb(1'b1, bcw_pkg::ADDR_CTRL, 32'h00000103);
		repeat (10) @(posedge clk_sys);
		rd(bcw_pkg::ADDR_STATUS, 32'h7, 32'h3, 1'b0);
		chk("refresh", 32'h0, {31'h0, refresh_allow});
		reset_pin_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		reset_pin_n <= 1'b1;
		rd(bcw_pkg::ADDR_STATUS, 32'h7, 32'h3, 1'b0);
		reset_pin_n <= 1'b0;
		repeat (7) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("restart", 32'h1, {31'h0, restart_q});
		chk("address", 32'h0, {12'h0, addr_out});
		@(posedge clk_sys);
		reset_pin_n <= 1'b1;
		stall <= 1'b0;
		rd(bcw_pkg::ADDR_STATUS, 32'h7, 32'h0, 1'b0);
		rd(bcw_pkg::ADDR_DWC, 32'hF0, 32'hF0, 1'b0);
		$display("wait and reset done");
		apb(1'b1, bcw_pkg::ADDR_CTRL, 32'h00000103);
		want <= 1'b1;
		for (int n = 0; n < 40 && bus_hold_grant_n !== 1'b0; n++) @(negedge clk_sys);
		repeat (3) @(negedge clk_sys);
		chk("float", 32'h1, {30'h0, bus_hold_grant_n, addr_oe_n & strobe_oe_n & data_oe_n});
		rd(bcw_pkg::ADDR_STATUS, 32'h17, 32'h15, 1'b0);
		want <= 1'b0;
		for (int n = 0; n < 40 && bus_hold_grant_n !== 1'b1; n++) @(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
		chk("drive", 32'h2, {30'h0, bus_hold_grant_n, addr_oe_n | strobe_oe_n});
		$display("release done");
		conclude();
	end
endmodule : bcw_top_test
